// >>> verif/pin_partner.sv
// Model of the outside pins: trigger and both capture inputs.
`timescale 1ns/10ps
module pin_partner (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       slow,
   input  wire logic [2:0] want,
   output logic            external_trigger_input,
   output logic            channel_a_pin_in,
   output logic            channel_b_pin_in
);
   logic [2:0] stage;
   // Pins move just after an edge; the slow setting adds one cycle of lag.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         stage <= 3'h0;
         {external_trigger_input, channel_a_pin_in, channel_b_pin_in} <= 3'h0;
      end
      else
      begin
         stage <= want;
         {external_trigger_input, channel_a_pin_in, channel_b_pin_in} <= slow ? stage : want;
      end
   end
endmodule : pin_partner

// >>> verif/tb_timer_pwm_pulse_capture.sv
// Self-checking bench for the timer channel pair.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module tb_timer_pwm_pulse_capture;
   import timer_pkg::*;
   logic             clk_sys, rst, ce, run_set, run_clear, slow;
   logic             compare_a_load, compare_b_load, external_trigger_input;
   logic             channel_a_pin_in, channel_b_pin_in, channel_a_pin_out;
   logic             channel_a_pin_oe, channel_b_pin_out, channel_b_pin_oe;
   logic             counter_run_bit;
   logic [2:0]       period_code_register, want;
   logic [9:0]       compare_load_value, counter_value, compare_a_register;
   logic [9:0]       compare_b_register, last;
   timer_ctrl_t      ctrl;
   channel_cfg_t     cfg_a, cfg_b;
   timer_event_t     events;
   op_mode_t         mode;
   int               n_fail, total_checks, na, nb, gap, hi;
   int               codes [3] = '{1, 3, 0};

   timer_pwm_pulse_capture dut (.*);
   pin_partner partner (.*);

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   always @(negedge clk_sys)
   begin
      na += (events.compare_a === 1'b1);
      nb += (events.compare_b === 1'b1);
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : chk

   task automatic ld(input logic b, input logic [9:0] v);
      compare_load_value <= v;
      compare_a_load <= !b;
      compare_b_load <= b;
      tick(1);
      compare_a_load <= 1'b0;
      compare_b_load <= 1'b0;
   endtask : ld

   task automatic go(input logic clr);
      run_set <= !clr;
      run_clear <= clr;
      tick(1);
      run_set <= 1'b0;
      run_clear <= 1'b0;
   endtask : go

   task automatic period_gap;
      int k;
      k = 0;
      gap = 0;
      hi = 0;
      while (events.period !== 1'b1 && k < 3000)
      begin
         tick(1);
         k++;
      end
      do
      begin
         tick(1);
         gap++;
         hi += (channel_b_pin_out === 1'b1);
      end while (events.period !== 1'b1 && gap < 3000);
   endtask : period_gap

   task automatic report_and_stop;
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #1600000;
      n_fail++;
      report_and_stop();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      {rst, ce} = 2'b11;
      {run_set, run_clear, slow, compare_a_load, compare_b_load} = 5'h00;
      {period_code_register, want, compare_load_value} = 16'h0000;
      {ctrl, cfg_a, cfg_b} = '0;
      tick(8);
      rst <= 1'b0;
      ld(0, 10'h006);
      ld(1, 10'h002);
      ctrl <= '{1'b1, 2'h0, 1'b0};
      period_code_register <= 3'h1;
      cfg_a <= '{`MODE_PWM_PULSE, `ACT_PULSE, 1'b1, 1'b0, 1'b1};
      cfg_b <= '{`MODE_PWM_PULSE, `ACT_PULSE, 1'b1, 1'b0, 1'b1};
      tick(2);
      chk("mode", OP_PULSE, mode);
      {na, nb, hi, last} = 0;
      go(0);
      repeat (12)
      begin
         tick(1);
         if (channel_a_pin_out === 1'b1)
            last = counter_value;
         hi += (channel_b_pin_out === 1'b1);
      end
      chk("pulse a", 10'h006, last);
      chk("pulse b", 4, hi);
      chk("run", 0, counter_run_bit);
      chk("events a", 1, na);
      chk("events b", 1, nb);
      ld(0, 10'h014);
      slow <= 1'b1;
      want <= 3'h4;
      tick(6);
      chk("trigger run", 1, counter_run_bit);
      go(1);
      tick(2);
      chk("run cleared", 0, counter_run_bit);
      chk("pin a", 0, channel_a_pin_out);
      slow <= 1'b0;
      want <= 3'h0;
      cfg_a <= '{`MODE_CAPTURE, `CAP_RISE, 1'b1, 1'b1, 1'b1};
      cfg_b <= '{`MODE_CAPTURE, `CAP_BOTH, 1'b0, 1'b1, 1'b1};
      period_code_register <= 3'h0;
      tick(2);
      go(0);
      tick(4);
      want <= 3'h2;
      tick(4);
      chk("capture a", 10'h005, compare_a_register);
      want <= 3'h0;
      tick(4);
      for (int s = 0; s < 4; s++)
      begin
         cfg_a.output_action <= 2'(s);
         tick(2);
         {na, nb} = 0;
         want <= 3'h3;
         tick(4);
         want <= 3'h0;
         tick(4);
         chk("capture count", (s == 3) ? 0 : (s == 2) ? 2 : 1, na);
         chk("capture b", 2, nb);
         if (s == 2)
            chk("capture ab", compare_a_register, compare_b_register);
      end
      period_code_register <= 3'h1;
      period_gap();
      period_gap();
      chk("wrap", 128, gap);
      go(1);
      ld(0, 10'h005);
      ld(1, 10'h002);
      ctrl <= '{1'b1, `ALIGN_CENTRE, 1'b0};
      cfg_a <= '{`MODE_PWM_PULSE, `ACT_PWM, 1'b1, 1'b0, 1'b1};
      cfg_b <= '{`MODE_PWM_PULSE, `ACT_PWM, 1'b1, 1'b0, 1'b1};
      tick(2);
      chk("mode", OP_PWM_CTR, mode);
      go(0);
      period_gap();
      period_gap();
      chk("period", 10, gap);
      chk("duty b", 3, hi);
      chk("a enable", 0, channel_a_pin_oe);
      cfg_b.output_action <= `ACT_FORCE_OFF;
      period_gap();
      period_gap();
      chk("forced", 0, hi);
      chk("period", 10, gap);
      cfg_b.output_action <= `ACT_PWM;
      ld(1, 10'h005);
      period_gap();
      period_gap();
      chk("full duty", 10, hi);
      ctrl.counter_clear_select <= 1'b0;
      foreach (codes[i])
      begin
         period_code_register <= 3'(codes[i]);
         period_gap();
         period_gap();
         chk("code period", (codes[i] == 0) ? 2046 : 256 * codes[i], gap);
         chk("code duty", 9, hi);
      end
      ctrl.pwm_alignment_select <= 2'h0;
      period_gap();
      period_gap();
      chk("edge period", 1024, gap);
      chk("edge duty", 5, hi);
      report_and_stop();
   end
endmodule : tb_timer_pwm_pulse_capture

// >>> verif/timer_pwm_pulse_capture_assertions.sv
// Port-level checks of the timer channel pair.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module timer_checks (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  timer_pkg::timer_ctrl_t  ctrl,
   input  timer_pkg::channel_cfg_t cfg_a,
   input  timer_pkg::channel_cfg_t cfg_b,
   input  wire logic              run_set,
   input  wire logic              run_clear,
   input  wire logic              compare_a_load,
   input  wire logic              external_trigger_input,
   input  wire logic              channel_a_pin_out,
   input  wire logic              channel_b_pin_out,
   input  wire logic              counter_run_bit,
   input  wire logic [`CNT_W-1:0] counter_value,
   input  wire logic [`CNT_W-1:0] compare_a_register,
   input  wire logic [`CNT_W-1:0] compare_b_register,
   input  timer_pkg::timer_event_t events,
   input  timer_pkg::op_mode_t     mode
);
   import timer_pkg::*;
   logic act_a;
   logic act_b;
   assign act_a = cfg_a.initial_state ^ cfg_a.polarity;
   assign act_b = cfg_b.initial_state ^ cfg_b.polarity;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   chk_pulse_start:
   assert property ($rose(counter_run_bit) && mode == OP_PULSE
      |-> counter_value == `CNT_ZERO && channel_a_pin_out == act_a) else $error("pulse start");
   chk_pulse_stop:
   assert property (mode == OP_PULSE && counter_run_bit && !run_set
      && counter_value == compare_a_register
      |=> !counter_run_bit && events.compare_a) else $error("pulse stop");
   chk_pulse_b:
   assert property (mode == OP_PULSE && counter_run_bit && counter_value == compare_b_register
      && counter_value != compare_a_register
      |=> events.compare_b && channel_b_pin_out == act_b) else $error("pulse b lead");
   chk_trig_run:
   assert property (mode == OP_PULSE && !ctrl.trigger_falling && !counter_run_bit
      && $rose(external_trigger_input) |-> ##[1:2] counter_run_bit) else $error("trigger");
   chk_cap_none:
   assert property (mode == OP_CAPTURE && cfg_a.output_action == `CAP_NONE && $stable(cfg_a)
      && !compare_a_load |=> $stable(compare_a_register)) else $error("capture off");
   chk_cap_free:
   assert property (mode == OP_CAPTURE && counter_run_bit && !run_clear && !run_set
      |=> counter_value == $past(counter_value) + `CNT_ONE || counter_value == `CNT_ZERO)
      else $error("free run");
   chk_ctr_turn:
   assert property (mode == OP_PWM_CTR && ctrl.counter_clear_select && counter_run_bit
      && !run_clear && counter_value == compare_a_register && counter_value != `CNT_ZERO
      |=> counter_value == $past(counter_value) - `CNT_ONE) else $error("turn");
   chk_ctr_event:
   assert property (mode == OP_PWM_CTR && counter_run_bit && !run_clear
      && counter_value == 10'h001 && $past(counter_value) == 10'h002
      |=> counter_value == `CNT_ZERO && events.period) else $error("period event");
   chk_force_off:
   assert property (mode == OP_PWM_CTR && cfg_b.output_action == `ACT_FORCE_OFF && $stable(cfg_b)
      |=> channel_b_pin_out == !act_b) else $error("force off");
endmodule : timer_checks

bind timer_pwm_pulse_capture timer_checks u_checks (.*);

// >>> verilog/edge_detect.sv
// Selectable edge detector for the trigger and capture pins.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module edge_detect (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       sig,
   input  wire logic [1:0] edge_select,
   output logic            hit
);
   logic sig_q;
   logic next_sig_q;

   always_comb
   begin
      next_sig_q = sig;
      case (edge_select)
         `CAP_RISE: hit = sig & ~sig_q;
         `CAP_FALL: hit = ~sig & sig_q;
         `CAP_BOTH: hit = sig ^ sig_q;
         default:   hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sig_q <= 1'b0;
      else if (ce)
         sig_q <= next_sig_q;
   end
endmodule : edge_detect

// >>> verilog/pwm_channel.sv
// Duty comparator and registered pin driver of one timer channel.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module pwm_channel (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  timer_pkg::channel_cfg_t       cfg,
   input  timer_pkg::op_mode_t           mode,
   input  wire logic [`CNT_W-1:0]        count,
   input  wire logic [`CNT_W-1:0]        duty,
   input  wire logic [`CNT_W-1:0]        limit,
   input  wire logic                     pulse_level,
   input  wire logic                     force_off,
   output logic                          pin_out,
   output logic                          pin_oe
);
   import timer_pkg::*;

   logic full;
   logic pwm_level;
   logic level;
   logic drive;
   logic next_pin_out;
   logic next_pin_oe;

   always_comb
   begin
      // Centre mode peaks once per period, so a duty equal to the peak is full.
      full = (mode == OP_PWM_CTR) ? (duty >= limit) : (duty > limit);
      pwm_level = full | (count < duty);
      level = 1'b0;
      drive = 1'b0;
      case (mode)
         OP_PWM_EDGE, OP_PWM_CTR:
         begin
            drive = 1'b1;
            case (cfg.output_action)
               `ACT_FORCE_OFF: level = 1'b0;
               `ACT_FORCE_ON:  level = 1'b1;
               default:        level = pwm_level;
            endcase
         end
         OP_PULSE:
         begin
            drive = 1'b1;
            level = pulse_level;
         end
         default:
         begin
            drive = 1'b0;
            level = 1'b0;
         end
      endcase
      next_pin_oe = drive & cfg.output_enable & ~force_off;
      next_pin_out = drive & ((level ? cfg.initial_state : ~cfg.initial_state) ^ cfg.polarity);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end
      else if (ce)
      begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end
endmodule : pwm_channel

// >>> verilog/timer_cfg.svh
// Constants for the enhanced timer channel: widths, field codes and count limits.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ***********************************************************************
// Widths
// ***********************************************************************
`define CNT_W            10
`define CODE_W           3
`define PERIOD_SHIFT     7

// ***********************************************************************
// Count limits
// ***********************************************************************
`define CNT_ZERO         10'h000
`define CNT_ONE          10'h001
`define CNT_MAX          10'h3ff
`define PERIOD_STEP_PAD  7'h00
`define CODE_MAX_RANGE   3'h0

// ***********************************************************************
// Channel mode select codes
// ***********************************************************************
`define MODE_CAPTURE     2'h1
`define MODE_PWM_PULSE   2'h2

// ***********************************************************************
// Output action codes
// ***********************************************************************
`define ACT_FORCE_OFF    2'h0
`define ACT_FORCE_ON     2'h1
`define ACT_PWM          2'h2
`define ACT_PULSE        2'h3
`define CAP_RISE         2'h0
`define CAP_FALL         2'h1
`define CAP_BOTH         2'h2
`define CAP_NONE         2'h3

// ***********************************************************************
// Alignment select code
// ***********************************************************************
`define ALIGN_CENTRE     2'h3

`endif

// >>> verilog/timer_pkg.sv
// Types shared by the enhanced timer channel modules.
package timer_pkg;

   // Per-channel configuration.
   typedef struct packed {
      logic [1:0] mode_select;
      logic [1:0] output_action;
      logic       initial_state;
      logic       polarity;
      logic       output_enable;
   } channel_cfg_t;

   // Controls common to both channels.
   typedef struct packed {
      logic       counter_clear_select;
      logic [1:0] pwm_alignment_select;
      logic       trigger_falling;
   } timer_ctrl_t;

   // One-cycle event pulses towards the interrupt logic.
   typedef struct packed {
      logic compare_a;
      logic compare_b;
      logic period;
   } timer_event_t;

   // Operating mode, one-hot.
   typedef enum logic [4:0] {
      OP_TIMER    = 5'b00001,
      OP_PWM_EDGE = 5'b00010,
      OP_PWM_CTR  = 5'b00100,
      OP_PULSE    = 5'b01000,
      OP_CAPTURE  = 5'b10000
   } op_mode_t;

endpackage : timer_pkg

// >>> verilog/timer_pwm_pulse_capture.sv
// Enhanced timer channel pair: PWM, single pulse and input capture.
//
// Contract
// - Centre PWM, clear-select low: period 256 per code step, code 000 gives 2046.
// - Centre PWM duty of each channel is twice its compare value minus one.
// - Centre PWM, clear-select high: period is twice compare A.
// - Output action 00 or 01 forces the pin; internal PWM keeps running.
// - Clear-select low: period code clears counter, A and B set duties.
// - Clear-select high: compare A sets period, B duty; A pin stays undriven.
// - Alignment select 11 selects centre-aligned PWM.
// - Centre PWM raises the period event when the down count reaches zero.
// - In pulse mode a run bit rise starts counting and raises pulse A.
// - In pulse mode a compare B match raises pulse B.
// - In pulse mode a trigger pin active edge sets the run bit.
// - Compare A match or software clear drops the run bit, ending both pulses.
// - Pulse B width is compare A minus compare B; pulse A width is compare A plus one.
// - Pulse mode raises compare A and compare B events on matches.
// - Pulse mode resets the counter only on run rise; period code unused.
// - Capture latches the counter into compare A or B and raises an event.
// - Capture edge is rising, falling or both; action 11 disables capture.
// - Capture counter free-runs, period match wraps it with an event.
// - Pin transitions capture even when the pin is driven as an output.
// - Capture mode ignores clear-select, initial state and polarity bits.
// - A duty at or above the period holds that output fully active.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module timer_pwm_pulse_capture (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  timer_pkg::timer_ctrl_t        ctrl,
   input  timer_pkg::channel_cfg_t       cfg_a,
   input  timer_pkg::channel_cfg_t       cfg_b,
   input  wire logic [`CODE_W-1:0]       period_code_register,
   input  wire logic                     run_set,
   input  wire logic                     run_clear,
   input  wire logic                     compare_a_load,
   input  wire logic                     compare_b_load,
   input  wire logic [`CNT_W-1:0]        compare_load_value,
   input  wire logic                     external_trigger_input,
   input  wire logic                     channel_a_pin_in,
   input  wire logic                     channel_b_pin_in,
   output logic                          channel_a_pin_out,
   output logic                          channel_a_pin_oe,
   output logic                          channel_b_pin_out,
   output logic                          channel_b_pin_oe,
   output logic                          counter_run_bit,
   output logic [`CNT_W-1:0]             counter_value,
   output logic [`CNT_W-1:0]             compare_a_register,
   output logic [`CNT_W-1:0]             compare_b_register,
   output timer_pkg::timer_event_t       events,
   output timer_pkg::op_mode_t           mode
);
   import timer_pkg::*;

   // ***********************************************************************
   // Helpers
   // ***********************************************************************
   // Top count for a period code; centre mode counts to the half period.
   function automatic logic [`CNT_W-1:0] period_limit(input logic [`CODE_W-1:0] code,
                                                      input logic               centre);
      logic [`CNT_W-1:0] base;
      base = {code, `PERIOD_STEP_PAD};
      if (code == `CODE_MAX_RANGE)
         period_limit = `CNT_MAX;
      else if (centre)
         period_limit = base;
      else
         period_limit = base - `CNT_ONE;
   endfunction : period_limit

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   op_mode_t          next_mode;
   logic              down;
   logic              next_down;
   logic              next_run;
   logic [`CNT_W-1:0] next_cnt;
   logic [`CNT_W-1:0] next_compare_a_register;
   logic [`CNT_W-1:0] next_compare_b_register;
   logic              pulse_b;
   logic              next_pulse_b;
   timer_event_t      next_events;
   logic [`CNT_W-1:0] limit;
   logic              match_a;
   logic              match_b;
   logic              wrap;
   logic              start;
   logic              trig_hit;
   logic              cap_a_hit;
   logic              cap_b_hit;
   logic              cap_a;
   logic              cap_b;
   logic              hold_a_pin;

   // ***********************************************************************
   // Mode decode
   // ***********************************************************************
   always_comb
   begin
      if (cfg_a.mode_select == `MODE_CAPTURE && cfg_b.mode_select == `MODE_CAPTURE)
         next_mode = OP_CAPTURE;
      else if (cfg_a.mode_select == `MODE_PWM_PULSE && cfg_b.mode_select == `MODE_PWM_PULSE
               && cfg_a.output_action == `ACT_PULSE && cfg_b.output_action == `ACT_PULSE)
         next_mode = OP_PULSE;
      else if (cfg_a.mode_select == `MODE_PWM_PULSE || cfg_b.mode_select == `MODE_PWM_PULSE)
         next_mode = (ctrl.pwm_alignment_select == `ALIGN_CENTRE) ? OP_PWM_CTR
                                                                  : OP_PWM_EDGE;
      else
         next_mode = OP_TIMER;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         mode <= OP_TIMER;
      else if (ce)
         mode <= next_mode;
   end

   // ***********************************************************************
   // Pin edge detectors
   // ***********************************************************************
   edge_detect u_trigger (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .ce          (ce),
      .sig         (external_trigger_input),
      .edge_select ({1'b0, ctrl.trigger_falling}),
      .hit         (trig_hit)
   );

   // Capture reads the pin level itself, whoever drives it.
   edge_detect u_capture_a (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .ce          (ce),
      .sig         (channel_a_pin_in),
      .edge_select (cfg_a.output_action),
      .hit         (cap_a_hit)
   );

   edge_detect u_capture_b (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .ce          (ce),
      .sig         (channel_b_pin_in),
      .edge_select (cfg_b.output_action),
      .hit         (cap_b_hit)
   );

   // ***********************************************************************
   // Counter, run bit and events
   // ***********************************************************************
   always_comb
   begin
      // Outside capture mode, clear-select picks compare A or the period code as period source.
      case (mode)
         OP_PWM_CTR:
            limit = ctrl.counter_clear_select ? compare_a_register
                                              : period_limit(period_code_register, 1'b1);
         OP_CAPTURE:
            limit = period_limit(period_code_register, 1'b0);
         default:
            limit = ctrl.counter_clear_select ? compare_a_register - `CNT_ONE
                                              : period_limit(period_code_register, 1'b0);
      endcase
      match_a = counter_value == compare_a_register;
      match_b = counter_value == compare_b_register;
      wrap = counter_value >= limit;
      cap_a = (mode == OP_CAPTURE) & cap_a_hit;
      cap_b = (mode == OP_CAPTURE) & cap_b_hit;

      // Setting the run bit wins over any clear in the same cycle.
      next_run = counter_run_bit;
      if (run_set || (mode == OP_PULSE && trig_hit))
         next_run = 1'b1;
      else if (run_clear || (mode == OP_PULSE && counter_run_bit && match_a))
         next_run = 1'b0;
      start = next_run & ~counter_run_bit;

      next_cnt = counter_value;
      next_down = down;
      next_events = '0;
      if (start)
      begin
         next_cnt = `CNT_ZERO;
         next_down = 1'b0;
      end
      else if (counter_run_bit)
      begin
         case (mode)
            OP_PWM_CTR:
            begin
               if (down)
               begin
                  if (counter_value == `CNT_ONE)
                  begin
                     next_cnt = `CNT_ZERO;
                     next_down = 1'b0;
                     next_events.period = 1'b1;
                  end
                  else if (counter_value != `CNT_ZERO)
                     next_cnt = counter_value - `CNT_ONE;
               end
               else if (wrap)
               begin
                  if (limit != `CNT_ZERO)
                  begin
                     next_cnt = counter_value - `CNT_ONE;
                     next_down = 1'b1;
                  end
               end
               else
                  next_cnt = counter_value + `CNT_ONE;
               next_events.compare_a = match_a;
               next_events.compare_b = match_b;
            end
            OP_PULSE:
            begin
               next_cnt = counter_value + `CNT_ONE;
               next_events.compare_a = match_a;
               next_events.compare_b = match_b;
            end
            OP_CAPTURE:
            begin
               next_cnt = wrap ? `CNT_ZERO : counter_value + `CNT_ONE;
               next_events.period = wrap;
            end
            default:
            begin
               next_cnt = wrap ? `CNT_ZERO : counter_value + `CNT_ONE;
               next_events.period = wrap & ~ctrl.counter_clear_select;
               next_events.compare_a = match_a;
               next_events.compare_b = match_b;
            end
         endcase
      end
      // Capture events do not depend on the run bit.
      if (cap_a)
         next_events.compare_a = 1'b1;
      if (cap_b)
         next_events.compare_b = 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         counter_run_bit <= 1'b0;
         counter_value <= `CNT_ZERO;
         down <= 1'b0;
         events <= '0;
      end
      else if (ce)
      begin
         counter_run_bit <= next_run;
         counter_value <= next_cnt;
         down <= next_down;
         events <= next_events;
      end
   end

   // ***********************************************************************
   // Compare registers
   // ***********************************************************************
   always_comb
   begin
      next_compare_a_register = compare_a_register;
      next_compare_b_register = compare_b_register;
      // A capture overrides a software load in the same cycle.
      if (cap_a)
         next_compare_a_register = counter_value;
      else if (compare_a_load)
         next_compare_a_register = compare_load_value;
      if (cap_b)
         next_compare_b_register = counter_value;
      else if (compare_b_load)
         next_compare_b_register = compare_load_value;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         compare_a_register <= `CNT_ZERO;
         compare_b_register <= `CNT_ZERO;
      end
      else if (ce)
      begin
         compare_a_register <= next_compare_a_register;
         compare_b_register <= next_compare_b_register;
      end
   end

   // ***********************************************************************
   // Single pulse channel B state
   // ***********************************************************************
   always_comb
   begin
      // Pulse B rises at the B match and falls with the run bit.
      next_pulse_b = (mode == OP_PULSE) & next_run & ~start
                     & (pulse_b | match_b);
      hold_a_pin = (mode == OP_PWM_EDGE || mode == OP_PWM_CTR)
                   & ctrl.counter_clear_select;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         pulse_b <= 1'b0;
      else if (ce)
         pulse_b <= next_pulse_b;
   end

   // ***********************************************************************
   // Channel outputs
   // ***********************************************************************
   pwm_channel u_chan_a (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .ce          (ce),
      .cfg         (cfg_a),
      .mode        (mode),
      .count       (counter_value),
      .duty        (compare_a_register),
      .limit       (limit),
      .pulse_level (next_run),
      .force_off   (hold_a_pin),
      .pin_out     (channel_a_pin_out),
      .pin_oe      (channel_a_pin_oe)
   );

   pwm_channel u_chan_b (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .ce          (ce),
      .cfg         (cfg_b),
      .mode        (mode),
      .count       (counter_value),
      .duty        (compare_b_register),
      .limit       (limit),
      .pulse_level (next_pulse_b),
      .force_off   (1'b0),
      .pin_out     (channel_b_pin_out),
      .pin_oe      (channel_b_pin_oe)
   );

endmodule : timer_pwm_pulse_capture
